// ===== pcg_pkg.sv
// Package for the peripheral clock gate control block.
// Assumes a 32-bit AHB-Lite slave with one word per register.
package pcg_pkg;
    // ==========================================
    // Register byte offsets
    localparam logic [7:0] PCG_OFF_CTRL_A = 8'h00;
    localparam logic [7:0] PCG_OFF_CTRL_B = 8'h04;
    localparam logic [7:0] PCG_OFF_CTRL_C = 8'h08;
    // ==========================================
    // Masks of implemented bits per register
    localparam logic [15:0] PCG_MASK_A = 16'hF9FB;
    localparam logic [15:0] PCG_MASK_B = 16'hC30F;
    localparam logic [15:0] PCG_MASK_C = 16'h07C0;
    // Value after reset: every peripheral enabled
    localparam logic [15:0] PCG_RESET_VAL = 16'h0000;
    // ==========================================
    // Field positions, register A
    localparam int PCG_A_TIMER_LO = 11;
    localparam int PCG_A_CODEC = 8;
    localparam int PCG_A_TWO_WIRE = 7;
    localparam int PCG_A_SERIAL_TWO = 6;
    localparam int PCG_A_SERIAL_ONE = 5;
    localparam int PCG_A_SYNC_TWO = 4;
    localparam int PCG_A_SYNC_ONE = 3;
    localparam int PCG_A_CAN = 1;
    localparam int PCG_A_CONVERTER = 0;
    // Field positions, register B
    localparam int PCG_B_CAPTURE_HI = 14;
    localparam int PCG_B_CAPTURE_LO = 8;
    localparam int PCG_B_COMPARE_LO = 0;
    // Field positions, register C
    localparam int PCG_C_COMPARATOR = 10;
    localparam int PCG_C_CALENDAR = 9;
    localparam int PCG_C_PARALLEL = 8;
    localparam int PCG_C_CHECKSUM = 7;
    localparam int PCG_C_DAC = 6;
    // ==========================================
    // Bus encodings
    localparam logic [1:0] PCG_HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] PCG_HTRANS_SEQ = 2'b11;
    localparam logic PCG_HRESP_OKAY = 1'b0;
endpackage : pcg_pkg

// ===== pcg_ctrl.sv
// Peripheral clock gate control: three disable registers on AHB-Lite
// and one registered enable per implemented disable bit.
// Assumes mclk_in is the system clock and peripherals own their gates.
//
// Contract
// - Register A bits 15..11 disable timers five..one
// - Register A bit 8 disables codec interface
// - A bits 7,6,5 disable two-wire, serial two, one
// - A bits 4,3 disable sync serial two, one
// - A bits 1,0 disable CAN and converter
// - B bits 15,14,9,8 disable captures 8,7,2,1
// - B bits 3..0 disable compares four..one
// - C bits 10,9,8 disable comparator, calendar, parallel
// - C bits 7,6 disable checksum unit and DAC
// - Unimplemented bit positions always read zero
// - Implemented bits read/write, cleared at reset
// - Disabled peripheral gets no clock, no access
// - Disable and enable take effect one cycle later
// - Runs only if enabled and present in variant
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module pcg_ctrl
    import pcg_pkg::*;
#(
    // Peripherals present in this variant, per register bit
    parameter logic [15:0] PRESENT_A = 16'hF9FB,
    parameter logic [15:0] PRESENT_B = 16'hC30F,
    parameter logic [15:0] PRESENT_C = 16'h07C0
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [7:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Peripheral clock enables, register A
    output logic [4:0] timer_en_out,
    output logic codec_iface_en_out,
    output logic two_wire_unit_en_out,
    output logic serial_port_two_en_out,
    output logic serial_port_one_en_out,
    output logic sync_serial_two_en_out,
    output logic sync_serial_one_en_out,
    output logic can_unit_en_out,
    output logic converter_en_out,
    // Peripheral clock enables, register B
    output logic [3:0] capture_en_out,
    output logic [3:0] compare_en_out,
    // Peripheral clock enables, register C
    output logic comparator_en_out,
    output logic calendar_clock_en_out,
    output logic parallel_port_en_out,
    output logic checksum_unit_en_out,
    output logic dac_unit_en_out
);

    // ==========================================
    // Address phase capture
    logic wr_pend_q; // Write data phase pending
    logic [7:0] wr_addr_q; // Address of pending write
    logic access_ok; // Valid transfer in address phase

    // Disable registers
    logic [15:0] ctrl_a_q;
    logic [15:0] ctrl_b_q;
    logic [15:0] ctrl_c_q;
    // Registered enables, all three registers
    logic [15:0] en_a_q;
    logic [15:0] en_b_q;
    logic [15:0] en_c_q;

    // Transfer is valid when selected, the bus is ready and htrans is NONSEQ or SEQ
    assign access_ok = hsel_in && hready_in &&
        (htrans_in == PCG_HTRANS_NONSEQ || htrans_in == PCG_HTRANS_SEQ);

    // Zero wait states, always OKAY
    assign hreadyout_out = 1'b1;
    assign hresp_out = PCG_HRESP_OKAY;

    // Latch write address for the data phase
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= access_ok && hwrite_in;
            if (access_ok) begin
                wr_addr_q <= haddr_in;
            end
        end
    end

    // ==========================================
    // Disable register writes; unimplemented bits forced to zero
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            ctrl_a_q <= PCG_RESET_VAL;
            ctrl_b_q <= PCG_RESET_VAL;
            ctrl_c_q <= PCG_RESET_VAL;
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                // Register A: timers, codec, serial, CAN, converter
                PCG_OFF_CTRL_A: begin
                    ctrl_a_q <= hwdata_in[15:0] & PCG_MASK_A;
                end
                // Register B: captures and compares
                PCG_OFF_CTRL_B: begin
                    ctrl_b_q <= hwdata_in[15:0] & PCG_MASK_B;
                end
                // Register C: comparator, calendar, parallel, etc.
                PCG_OFF_CTRL_C: begin
                    ctrl_c_q <= hwdata_in[15:0] & PCG_MASK_C;
                end
                // Unmapped write is ignored
                default: begin
                    ctrl_a_q <= ctrl_a_q;
                end
            endcase
        end
    end

    // ==========================================
    // Read data, registered at the address phase
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            hrdata_out <= 32'h0000_0000;
        end else if (access_ok && !hwrite_in) begin
            case (haddr_in)
                // Upper bits and unimplemented bits read zero
                PCG_OFF_CTRL_A: begin
                    hrdata_out <= {16'h0000, ctrl_a_q};
                end
                PCG_OFF_CTRL_B: begin
                    hrdata_out <= {16'h0000, ctrl_b_q};
                end
                PCG_OFF_CTRL_C: begin
                    hrdata_out <= {16'h0000, ctrl_c_q};
                end
                // Unmapped reads return zero
                default: begin
                    hrdata_out <= 32'h0000_0000;
                end
            endcase
        end
    end

    // ==========================================
    // Enables: inverted disable bit, gated by presence, one cycle later
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            en_a_q <= 16'h0000;
            en_b_q <= 16'h0000;
            en_c_q <= 16'h0000;
        end else begin
            en_a_q <= ~ctrl_a_q & PRESENT_A & PCG_MASK_A;
            en_b_q <= ~ctrl_b_q & PRESENT_B & PCG_MASK_B;
            en_c_q <= ~ctrl_c_q & PRESENT_C & PCG_MASK_C;
        end
    end

    // ==========================================
    // Enable outputs; a low enable stops the peripheral clock and access
    // Timers five..one from bits 15..11
    assign timer_en_out = en_a_q[PCG_A_TIMER_LO +: 5];
    assign codec_iface_en_out = en_a_q[PCG_A_CODEC];
    assign two_wire_unit_en_out = en_a_q[PCG_A_TWO_WIRE];
    assign serial_port_two_en_out = en_a_q[PCG_A_SERIAL_TWO];
    assign serial_port_one_en_out = en_a_q[PCG_A_SERIAL_ONE];
    assign sync_serial_two_en_out = en_a_q[PCG_A_SYNC_TWO];
    assign sync_serial_one_en_out = en_a_q[PCG_A_SYNC_ONE];
    assign can_unit_en_out = en_a_q[PCG_A_CAN];
    assign converter_en_out = en_a_q[PCG_A_CONVERTER];
    // Captures 8,7 from bits 15,14 and 2,1 from bits 9,8
    assign capture_en_out = {en_b_q[PCG_B_CAPTURE_HI +: 2],
        en_b_q[PCG_B_CAPTURE_LO +: 2]};
    // Compares four..one from bits 3..0
    assign compare_en_out = en_b_q[PCG_B_COMPARE_LO +: 4];
    assign comparator_en_out = en_c_q[PCG_C_COMPARATOR];
    assign calendar_clock_en_out = en_c_q[PCG_C_CALENDAR];
    assign parallel_port_en_out = en_c_q[PCG_C_PARALLEL];
    assign checksum_unit_en_out = en_c_q[PCG_C_CHECKSUM];
    assign dac_unit_en_out = en_c_q[PCG_C_DAC];

    // ==========================================
    // Assertions
    // Cleared register A disable bit yields enable next cycle when present
    property p_enable_follow;
        @(posedge mclk_in) disable iff (!rst_b_in)
        1'b1 |=> en_a_q == (~$past(ctrl_a_q) & PRESENT_A & PCG_MASK_A);
    endproperty
    a_enable_follow: assert property (p_enable_follow)
        else $error("register A enables do not follow disable bits");

    property p_unimpl_zero;
        @(posedge mclk_in) disable iff (!rst_b_in)
        ((ctrl_a_q & ~PCG_MASK_A) == 16'h0000) &&
        ((ctrl_b_q & ~PCG_MASK_B) == 16'h0000) &&
        ((ctrl_c_q & ~PCG_MASK_C) == 16'h0000);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented bit is set");

    property p_write_b;
        @(posedge mclk_in) disable iff (!rst_b_in)
        wr_pend_q && wr_addr_q == PCG_OFF_CTRL_B
        |=> ctrl_b_q == ($past(hwdata_in[15:0]) & PCG_MASK_B);
    endproperty
    a_write_b: assert property (p_write_b)
        else $error("register B write not stored");

    property p_read_c;
        @(posedge mclk_in) disable iff (!rst_b_in)
        access_ok && !hwrite_in && haddr_in == PCG_OFF_CTRL_C
        |=> hrdata_out == {16'h0000, $past(ctrl_c_q)};
    endproperty
    a_read_c: assert property (p_read_c)
        else $error("register C read data wrong");

    property p_timer_gate;
        @(posedge mclk_in) disable iff (!rst_b_in)
        $past(ctrl_a_q[15]) |-> !timer_en_out[4];
    endproperty
    a_timer_gate: assert property (p_timer_gate)
        else $error("timer five enabled while disabled");

    property p_codec_gate;
        @(posedge mclk_in) disable iff (!rst_b_in)
        $rose(ctrl_a_q[8]) |=> !codec_iface_en_out;
    endproperty
    a_codec_gate: assert property (p_codec_gate)
        else $error("codec interface not disabled a cycle later");

    property p_serial_gate;
        @(posedge mclk_in) disable iff (!rst_b_in)
        $fell(ctrl_a_q[5]) && PRESENT_A[5] |=> serial_port_one_en_out;
    endproperty
    a_serial_gate: assert property (p_serial_gate)
        else $error("serial port one not re-enabled");

    property p_capture_gate;
        @(posedge mclk_in) disable iff (!rst_b_in)
        capture_en_out[3] |-> $past(!ctrl_b_q[15]) && PRESENT_B[15];
    endproperty
    a_capture_gate: assert property (p_capture_gate)
        else $error("capture eight enabled while disabled");

    property p_dac_gate;
        @(posedge mclk_in) disable iff (!rst_b_in)
        dac_unit_en_out |-> $past(!ctrl_c_q[6]) && PRESENT_C[6];
    endproperty
    a_dac_gate: assert property (p_dac_gate)
        else $error("DAC enabled while disabled");

    // A write to register A stores the masked low half-word
    property p_write_a;
        @(posedge mclk_in) disable iff (!rst_b_in)
        wr_pend_q && wr_addr_q == PCG_OFF_CTRL_A
        |=> ctrl_a_q == ($past(hwdata_in[15:0]) & PCG_MASK_A);
    endproperty
    a_write_a: assert property (p_write_a)
        else $error("register A write not stored");

    // Synchronous reset clears registers, register A enables and read data
    property p_reset_clear;
        @(posedge mclk_in)
        !rst_b_in |=> ctrl_a_q == PCG_RESET_VAL &&
            ctrl_b_q == PCG_RESET_VAL && ctrl_c_q == PCG_RESET_VAL &&
            en_a_q == 16'h0000 && hrdata_out == 32'h0000_0000;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("state not cleared by reset");

    // Upper half of the read word always reads zero
    property p_read_upper;
        @(posedge mclk_in) disable iff (!rst_b_in)
        hrdata_out[31:16] == 16'h0000;
    endproperty
    a_read_upper: assert property (p_read_upper)
        else $error("upper read data not zero");

    // Reads outside the three registers return zero
    property p_unmapped_read;
        @(posedge mclk_in) disable iff (!rst_b_in)
        access_ok && !hwrite_in && haddr_in != PCG_OFF_CTRL_A &&
        haddr_in != PCG_OFF_CTRL_B && haddr_in != PCG_OFF_CTRL_C
        |=> hrdata_out == 32'h0000_0000;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read not zero");

    // Sync serial enables follow their bits one cycle late
    property p_sync_gate;
        @(posedge mclk_in) disable iff (!rst_b_in)
        $past(rst_b_in) |->
            {sync_serial_two_en_out, sync_serial_one_en_out} ==
            (~$past(ctrl_a_q[4:3]) & PRESENT_A[4:3]);
    endproperty
    a_sync_gate: assert property (p_sync_gate)
        else $error("sync serial enables wrong");

    // CAN and converter enables follow their bits one cycle late
    property p_can_gate;
        @(posedge mclk_in) disable iff (!rst_b_in)
        $past(rst_b_in) |->
            {can_unit_en_out, converter_en_out} ==
            (~$past(ctrl_a_q[1:0]) & PRESENT_A[1:0]);
    endproperty
    a_can_gate: assert property (p_can_gate)
        else $error("CAN or converter enable wrong");

    // Compare enables follow their bits one cycle late
    property p_compare_gate;
        @(posedge mclk_in) disable iff (!rst_b_in)
        $past(rst_b_in) |->
            compare_en_out == (~$past(ctrl_b_q[3:0]) & PRESENT_B[3:0]);
    endproperty
    a_compare_gate: assert property (p_compare_gate)
        else $error("compare enables wrong");

    // Comparator, calendar and parallel port enables
    property p_calendar_gate;
        @(posedge mclk_in) disable iff (!rst_b_in)
        $past(rst_b_in) |->
            {comparator_en_out, calendar_clock_en_out,
            parallel_port_en_out} ==
            (~$past(ctrl_c_q[10:8]) & PRESENT_C[10:8]);
    endproperty
    a_calendar_gate: assert property (p_calendar_gate)
        else $error("register C upper enables wrong");

    // No enable stays high once its disable bit was set
    property p_no_clock_off;
        @(posedge mclk_in) disable iff (!rst_b_in)
        ((en_a_q & $past(ctrl_a_q)) == 16'h0000) &&
        ((en_b_q & $past(ctrl_b_q)) == 16'h0000) &&
        ((en_c_q & $past(ctrl_c_q)) == 16'h0000);
    endproperty
    a_no_clock_off: assert property (p_no_clock_off)
        else $error("disabled peripheral still clocked");

    // Units absent from this variant never get a clock
    property p_present_only;
        @(posedge mclk_in) disable iff (!rst_b_in)
        ((en_a_q & ~PRESENT_A) == 16'h0000) &&
        ((en_b_q & ~PRESENT_B) == 16'h0000) &&
        ((en_c_q & ~PRESENT_C) == 16'h0000);
    endproperty
    a_present_only: assert property (p_present_only)
        else $error("absent unit enabled");

endmodule : pcg_ctrl

// ===== pcg_periph_model.sv
// Model of the peripherals that receive the gated clocks.
// Assumes enables arrive registered from the gate control block.
`timescale 1ns/1ps
module pcg_periph_model #(
    parameter int N = 26
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // Clock enables from the gate control
    input wire logic [N-1:0] en_in,
    // Divider state, one bit per unit
    output logic [N-1:0] tog_out
);
    // ==========================================
    // Each divider moves only while its clock runs
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            tog_out <= '0;
        end else begin
            tog_out <= tog_out ^ en_in;
        end
    end
endmodule : pcg_periph_model

// ===== tb.sv
// Testbench for the clock gate control with a register model.
// Assumes one AHB-Lite slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
module tb
    import pcg_pkg::*;
;
    // ==========================================
    // Bus, clock and enable signals
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic [31:0] hwdata = 32'h0000_0000;
    wire logic [31:0] hrdata;
    wire logic hready;
    wire logic hresp;
    wire logic [25:0] en;
    wire logic [25:0] tog;
    // Model state and bookkeeping
    logic [15:0] mdl [3];
    logic [15:0] msk [3] = '{PCG_MASK_A, PCG_MASK_B, PCG_MASK_C};
    logic [31:0] r;
    int mismatches = 0;
    int n_compared = 0;
    int seed = 32'h7609;
    pcg_ctrl i_dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .timer_en_out(en[25:21]),
        .codec_iface_en_out(en[20]), .two_wire_unit_en_out(en[19]),
        .serial_port_two_en_out(en[18]), .serial_port_one_en_out(en[17]),
        .sync_serial_two_en_out(en[16]), .sync_serial_one_en_out(en[15]),
        .can_unit_en_out(en[14]), .converter_en_out(en[13]),
        .capture_en_out(en[12:9]), .compare_en_out(en[8:5]),
        .comparator_en_out(en[4]), .calendar_clock_en_out(en[3]),
        .parallel_port_en_out(en[2]), .checksum_unit_en_out(en[1]),
        .dac_unit_en_out(en[0]));
    pcg_periph_model #(.N(26)) i_periph (.mclk_in(mclk_in),
        .rst_b_in(rst_b_in), .en_in(en), .tog_out(tog));
    // 200 MHz clock
    initial begin
        forever #2.5 mclk_in = ~mclk_in;
    end
    // Expected enables: inverted disable bits in port order
    function automatic logic [25:0] exp_en();
        return ~{mdl[0][15:11], mdl[0][8], mdl[0][7:3], mdl[0][1:0],
            mdl[1][15:14], mdl[1][9:8], mdl[1][3:0], mdl[2][10:6]};
    endfunction : exp_en
    // Verdict and end of run
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Bounded wait for hready at a rising edge
    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge mclk_in);
            k++;
        end while (hready !== 1'b1 && k < 50);
        if (k >= 50) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, hready, 1'b1);
            end_sim();
        end
    endtask : wait_rdy
    // One single AHB transfer, address then data phase
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= PCG_HTRANS_NONSEQ;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
        chk({31'h0, hresp}, {31'h0, PCG_HRESP_OKAY});
    endtask : xfer
    // Write, then watch enables hold one cycle and then follow
    task automatic wr(input int i, input logic [31:0] d);
        logic [25:0] old;
        logic [25:0] t0;
        old = exp_en();
        xfer(1'b1, 8'(i * 4), d);
        mdl[i] = d[15:0] & msk[i];
        #1;
        chk({6'h0, en}, {6'h0, old});
        @(posedge mclk_in);
        #1;
        t0 = tog;
        chk({6'h0, en}, {6'h0, exp_en()});
        @(posedge mclk_in);
        #1;
        chk({6'h0, tog ^ t0}, {6'h0, exp_en()});
    endtask : wr
    task automatic rd_all();
        for (int i = 0; i < 3; i++) begin
            xfer(1'b0, 8'(i * 4), 32'h0000_0000);
            chk(r, {16'h0000, mdl[i]});
        end
    endtask : rd_all
    // ==========================================
    // Main sequence
    initial begin
        mdl = '{16'h0000, 16'h0000, 16'h0000};
        repeat (3) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        rd_all();
        @(posedge mclk_in);
        #1;
        chk({6'h0, en}, {6'h0, exp_en()});
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            for (int n = 0; n < 6; n++) begin
                wr(i, (n == 0) ? 32'hFFFF_FFFF : $random(seed));
                rd_all();
            end
        end
        $display("test random done");
        xfer(1'b1, 8'h0C, 32'hFFFF_FFFF);
        xfer(1'b0, 8'h0C, 32'h0000_0000);
        chk(r, 32'h0000_0000);
        rd_all();
        $display("test unmapped done");
        xfer(1'b1, PCG_OFF_CTRL_B, 32'h0000_0005);
        mdl[1] = 16'h0005;
        xfer(1'b0, PCG_OFF_CTRL_B, 32'h0000_0000);
        chk(r, {16'h0000, mdl[1]});
        rd_all();
        $display("test back to back done");
        rst_b_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        chk({6'h0, en}, 32'h0000_0000);
        rst_b_in <= 1'b1;
        mdl = '{16'h0000, 16'h0000, 16'h0000};
        rd_all();
        @(posedge mclk_in);
        #1;
        chk({6'h0, en}, {6'h0, exp_en()});
        $display("test second reset done");
        end_sim();
    end
endmodule : tb
